/* File: fts_regs.sv */
// Purpose: flash timing divider, security word and sector protection registers
// Assumes: AHB-Lite slave, whole-word single transfers, sys_clk at 50 MHz
// Notes: configuration field values are sampled in the first cycle after reset
//
// Behaviour
// - divider bit 7 reads 0 until first divider write, then 1 until reset
// - divider bits 6:0 take only the first write; bit 7 never writable
// - prescale bit 6 divides the flash bus clock by 8 before the divider
// - six-bit divide field further divides, giving the program/erase timing clock
// - security word shows bits 31, 30, 15:0 only; others zero; nothing writable
// - security bit 31 enables backdoor key unlocking
// - security bit 30 shows whether flash security is active
// - security code field equal to 0x4ac8 means secured; anything else unsecured
// - security word loads from the configuration field in the first cycle after reset
// - protection and privilege maps load from the configuration field in the first cycle after reset
// - protection map always readable, writable only while module lock is clear
// - protection bit M set refuses program and erase of sector M
// - flash is split into 16 kbyte logical sectors for protection
// - privilege map always readable, writable only while module lock is clear
// - privilege bit M set restricts sector M to supervisor space
// - module lock can only be set; when set, both maps are write-locked
`timescale 1ns/1ps
`include "fts_params.svh"

module fts_regs (
   input wire logic sys_clk,
   input wire logic rst,
   // ahb-lite slave port
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // configuration field contents, valid from reset release
   input wire logic [31:0] cfg_security_word,
   input wire logic [31:0] cfg_write_protect,
   input wire logic [31:0] cfg_privilege_map,
   // flash array access check
   input wire logic access_valid,
   input wire logic [18:0] access_addr,
   input wire logic access_user,
   input wire logic access_program_erase,
   output logic access_bus_error,
   output logic program_erase_refused,
   // state shown to the rest of the flash module
   output logic timing_tick,
   output logic backdoor_key_enable,
   output logic security_active,
   output logic module_lock
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   fts_pkg::fts_bus_state_type bus_state_reg;
   fts_pkg::fts_bus_state_type bus_state_next;
   logic [7:0] addr_reg;
   logic load_pending_reg;
   logic lock_reg;
   logic divider_loaded_reg;
   logic [6:0] divider_reg;
   logic backdoor_key_reg;
   logic security_active_reg;
   logic [15:0] security_code_reg;
   fts_pkg::fts_word_type write_protect_reg;
   fts_pkg::fts_word_type privilege_map_reg;
   logic [31:0] hrdata_reg;
   logic take_request;
   logic write_phase;

   // ***************************************************************
   // helpers
   // ***************************************************************

   // address match within the block; used by both write and read paths
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
      hits = (addr == offset);
   endfunction : hits

   // secured only on the exact code, so stray data rarely locks the part
   function automatic logic code_secures(input logic [15:0] code);
      code_secures = (code == `FTS_SECURED_CODE);
   endfunction : code_secures

   // ***************************************************************
   // bus slave sequencing
   // ***************************************************************

   // a transfer is taken when selected, nonseq or seq, and the bus is ready
   assign take_request = hsel && htrans[1] && hready && !load_pending_reg;
   assign write_phase = (bus_state_reg == fts_pkg::BUS_WRITE);

   // reads take one wait state so they always see a preceding write
   always_comb begin
      bus_state_next = bus_state_reg;
      unique case (bus_state_reg)
         fts_pkg::BUS_IDLE,
         fts_pkg::BUS_WRITE,
         fts_pkg::BUS_READ_DONE: begin
            if (take_request) begin
               bus_state_next = hwrite ? fts_pkg::BUS_WRITE : fts_pkg::BUS_READ_WAIT;
            end else begin
               bus_state_next = fts_pkg::BUS_IDLE;
            end
         end
         fts_pkg::BUS_READ_WAIT: begin
            bus_state_next = fts_pkg::BUS_READ_DONE;
         end
      endcase
   end

   // state register of the bus slave
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bus_state_reg <= fts_pkg::BUS_IDLE;
      end else begin
         bus_state_reg <= bus_state_next;
      end
   end

   // address phase capture; hsize is ignored as only whole words are used
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_reg <= 8'h00;
      end else if (take_request) begin
         addr_reg <= haddr[`FTS_BUS_ADDR_BITS-1:0];
      end
   end

   // not ready while the reset load runs or in the read wait state
   assign hreadyout = !load_pending_reg && (bus_state_reg != fts_pkg::BUS_READ_WAIT);
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // ***************************************************************
   // reset load from the configuration field
   // ***************************************************************

   // async reset takes constants only; the field is sampled after release
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         load_pending_reg <= 1'b1;
      end else begin
         load_pending_reg <= 1'b0;
      end
   end

   // ***************************************************************
   // module lock
   // ***************************************************************

   // set-only: a write of 0 never clears it, only reset does
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lock_reg <= 1'b0;
      end else if (write_phase && hits(addr_reg, `FTS_OFF_MODULE_CONFIG)
                   && hwdata[`FTS_BIT_MODULE_LOCK]) begin
         lock_reg <= 1'b1;
      end
   end

   // ***************************************************************
   // timing divider
   // ***************************************************************

   // first write loads the field and raises the loaded flag; later writes drop
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         divider_reg <= 7'(`FTS_RESET_DIVIDER); // loaded flag is kept in its own flop
         divider_loaded_reg <= 1'b0;
      end else if (write_phase && hits(addr_reg, `FTS_OFF_TIMING_DIVIDER)
                   && !divider_loaded_reg) begin
         divider_reg <= hwdata[`FTS_BIT_PRESCALE_BY_EIGHT:0];
         divider_loaded_reg <= 1'b1;
      end
   end

   // timing tick runs only once software has set the divider
   fts_timing_clock u_timing_clock (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(divider_loaded_reg),
      .prescale_by_eight(divider_reg[`FTS_BIT_PRESCALE_BY_EIGHT]),
      .divide_field(divider_reg[`FTS_DIVIDE_MSB:0]),
      .timing_tick(timing_tick)
   );

   // ***************************************************************
   // security word
   // ***************************************************************

   // read-only; loaded once from the field, secure state decoded at load
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         backdoor_key_reg <= 1'b0;
         security_code_reg <= 16'h0000;
         security_active_reg <= 1'b0;
      end else if (load_pending_reg) begin
         backdoor_key_reg <= cfg_security_word[`FTS_BIT_BACKDOOR_KEY];
         security_code_reg <= cfg_security_word[`FTS_SECURITY_CODE_MSB:0];
         security_active_reg <= code_secures(
            cfg_security_word[`FTS_SECURITY_CODE_MSB:0]);
      end
   end

   assign backdoor_key_enable = backdoor_key_reg;
   assign security_active = security_active_reg;
   assign module_lock = lock_reg;

   // ***************************************************************
   // sector protection and privilege maps
   // ***************************************************************

   // protection map: field value at reset, bus writes only while unlocked
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         write_protect_reg <= `FTS_RESET_WORD;
      end else if (load_pending_reg) begin
         write_protect_reg <= cfg_write_protect;
      end else if (write_phase && hits(addr_reg, `FTS_OFF_WRITE_PROTECT) && !lock_reg) begin
         write_protect_reg <= hwdata;
      end
   end

   // privilege map: same lock gating as the protection map
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         privilege_map_reg <= `FTS_RESET_WORD;
      end else if (load_pending_reg) begin
         privilege_map_reg <= cfg_privilege_map;
      end else if (write_phase && hits(addr_reg, `FTS_OFF_PRIVILEGE_MAP) && !lock_reg) begin
         privilege_map_reg <= hwdata;
      end
   end

   // checks of flash array accesses against both maps
   fts_sector_check u_sector_check (
      .sys_clk(sys_clk),
      .rst(rst),
      .write_protect(write_protect_reg),
      .privilege_map(privilege_map_reg),
      .access_valid(access_valid),
      .access_addr(access_addr),
      .access_user(access_user),
      .access_program_erase(access_program_erase),
      .access_bus_error(access_bus_error),
      .program_erase_refused(program_erase_refused)
   );

   // ***************************************************************
   // read data
   // ***************************************************************

   // sampled in the wait state so a write just before is already visible
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hrdata_reg <= `FTS_RESET_WORD;
      end else if (bus_state_reg == fts_pkg::BUS_READ_WAIT) begin
         hrdata_reg <= `FTS_RESET_WORD;
         if (hits(addr_reg, `FTS_OFF_MODULE_CONFIG)) begin
            hrdata_reg[`FTS_BIT_MODULE_LOCK] <= lock_reg;
         end else if (hits(addr_reg, `FTS_OFF_TIMING_DIVIDER)) begin
            hrdata_reg[`FTS_BIT_DIVIDER_LOADED] <= divider_loaded_reg;
            hrdata_reg[`FTS_BIT_PRESCALE_BY_EIGHT:0] <= divider_reg;
         end else if (hits(addr_reg, `FTS_OFF_SECURITY_WORD)) begin
            hrdata_reg[`FTS_BIT_BACKDOOR_KEY] <= backdoor_key_reg;
            hrdata_reg[`FTS_BIT_SECURITY_ACTIVE] <= security_active_reg;
            hrdata_reg[`FTS_SECURITY_CODE_MSB:0] <= security_code_reg;
         end else if (hits(addr_reg, `FTS_OFF_WRITE_PROTECT)) begin
            hrdata_reg <= write_protect_reg;
         end else if (hits(addr_reg, `FTS_OFF_PRIVILEGE_MAP)) begin
            hrdata_reg <= privilege_map_reg;
         end
      end
   end

endmodule : fts_regs

/* File: fts_params.svh */
// Purpose: constants of the flash timing, security and protection register bank
// Assumes: 32-bit word registers on an AHB-Lite slave port
// Notes: offsets are byte addresses within the block
`ifndef FTS_PARAMS_SVH
`define FTS_PARAMS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define FTS_OFF_MODULE_CONFIG 8'h00
`define FTS_OFF_TIMING_DIVIDER 8'h04
`define FTS_OFF_SECURITY_WORD 8'h08
`define FTS_OFF_WRITE_PROTECT 8'h10
`define FTS_OFF_PRIVILEGE_MAP 8'h14

// ***************************************************************
// field positions
// ***************************************************************
`define FTS_BIT_MODULE_LOCK 10
`define FTS_BIT_DIVIDER_LOADED 7
`define FTS_BIT_PRESCALE_BY_EIGHT 6
`define FTS_DIVIDE_MSB 5
`define FTS_BIT_BACKDOOR_KEY 31
`define FTS_BIT_SECURITY_ACTIVE 30
`define FTS_SECURITY_CODE_MSB 15
`define FTS_SECTOR_LSB 14
`define FTS_SECTOR_MSB 18

// ***************************************************************
// values and counts
// ***************************************************************
`define FTS_SECURED_CODE 16'h4ac8
`define FTS_PRESCALE_LAST 3'h7
`define FTS_RESET_WORD 32'h0000_0000
`define FTS_RESET_DIVIDER 8'h00
`define FTS_BUS_ADDR_BITS 8

`endif

/* File: fts_pkg.sv */
// Purpose: types shared by the flash timing, security and protection register bank
// Assumes: constants live in fts_params.svh
// Notes: no constants here, types only
package fts_pkg;

   // bus slave sequencing of one transfer
   typedef enum logic [1:0] {
      BUS_IDLE,
      BUS_WRITE,
      BUS_READ_WAIT,
      BUS_READ_DONE
   } fts_bus_state_type;

   typedef logic [31:0] fts_word_type;

endpackage : fts_pkg

/* File: fts_timing_clock.sv */
// Purpose: program/erase timing tick from the flash bus clock
// Assumes: sys_clk is the flash bus clock
// Notes: tick is a one-cycle enable, not a clock
`timescale 1ns/1ps
`include "fts_params.svh"

module fts_timing_clock (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic prescale_by_eight,
   input wire logic [5:0] divide_field,
   output logic timing_tick
);

   logic [2:0] pre_count_reg;
   logic [5:0] div_count_reg;
   logic pre_tick;

   // the prescaler passes every edge when off, one in eight when on
   assign pre_tick = !prescale_by_eight || (pre_count_reg == `FTS_PRESCALE_LAST);

   // prescale counter, held clear until the divider has been loaded
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pre_count_reg <= 3'h0;
      end else if (!enable || !prescale_by_eight) begin
         pre_count_reg <= 3'h0;
      end else begin
         pre_count_reg <= pre_count_reg + 3'h1;
      end
   end

   // divide by field plus one, so a zero field still yields a tick
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_count_reg <= 6'h00;
         timing_tick <= 1'b0;
      end else if (!enable) begin
         div_count_reg <= 6'h00;
         timing_tick <= 1'b0;
      end else begin
         timing_tick <= 1'b0;
         if (pre_tick) begin
            if (div_count_reg >= divide_field) begin
               div_count_reg <= 6'h00;
               timing_tick <= 1'b1;
            end else begin
               div_count_reg <= div_count_reg + 6'h01;
            end
         end
      end
   end

endmodule : fts_timing_clock

/* File: fts_sector_check.sv */
// Purpose: per-sector protection and privilege check of flash accesses
// Assumes: one logical sector per 16 kbyte of flash address
// Notes: verdicts are registered, one cycle after the request
`timescale 1ns/1ps
`include "fts_params.svh"

module fts_sector_check (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [31:0] write_protect,
   input wire logic [31:0] privilege_map,
   input wire logic access_valid,
   input wire logic [18:0] access_addr,
   input wire logic access_user,
   input wire logic access_program_erase,
   output logic access_bus_error,
   output logic program_erase_refused
);

   logic [4:0] sector;

   // sector index is the 16 kbyte block number within the flash
   assign sector = access_addr[`FTS_SECTOR_MSB:`FTS_SECTOR_LSB];

   // verdicts: user access to supervisor sector, program/erase to protected sector
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         access_bus_error <= 1'b0;
         program_erase_refused <= 1'b0;
      end else begin
         access_bus_error <= access_valid && access_user && privilege_map[sector];
         program_erase_refused <= access_valid && access_program_erase
            && write_protect[sector];
      end
   end

endmodule : fts_sector_check

/* File: fts_regs_props.sv */
// Purpose: port-level checker for the flash timing, security and protection register bank
// Assumes: one clock domain, rst asynchronous active high, hready tied to hreadyout
// Notes: register contents are hidden, so checks tie outputs to the bus and access inputs
`timescale 1ns/1ps

module fts_regs_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] cfg_security_word,
   input wire logic access_valid,
   input wire logic access_user,
   input wire logic access_program_erase,
   input wire logic access_bus_error,
   input wire logic program_erase_refused,
   input wire logic timing_tick,
   input wire logic backdoor_key_enable,
   input wire logic security_active,
   input wire logic module_lock
);
   // ***************************************************************
   // helper state
   // ***************************************************************
   logic [1:0] boot_cnt;
   logic div_seen;
   logic lock_pend;
   logic taken;

   // a transfer is accepted only when both sides are ready
   assign taken = hsel && htrans[1] && hready && hreadyout;

   // cycles since reset release, saturating so it stays cheap
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         boot_cnt <= 2'h0;
      end else if (boot_cnt != 2'h3) begin
         boot_cnt <= boot_cnt + 2'h1;
      end
   end

   // remembers a divider write address phase since reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_seen <= 1'b0;
      end else if (taken && hwrite && haddr[7:0] == 8'h04) begin
         div_seen <= 1'b1;
      end
   end

   // marks the data phase of a module config write
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lock_pend <= 1'b0;
      end else if (hready) begin
         lock_pend <= taken && hwrite && haddr[7:0] == 8'h00;
      end
   end

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // looked at two edges after release so the reset edge itself never starts an attempt
   boot_ready_a: assert property (boot_cnt == 2'h1 |-> hreadyout && $past(!hreadyout))
      else $error("bus ready wrong after reset");
   read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   refuse_cause_a: assert property (program_erase_refused |->
      $past(access_valid && access_program_erase))
      else $error("refusal without a program or erase request");
   buserr_cause_a: assert property (access_bus_error |->
      $past(access_valid && access_user))
      else $error("bus error without a user access");
   tick_load_a: assert property (timing_tick |-> div_seen)
      else $error("timing tick before divider write");
   lock_sticky_a: assert property (boot_cnt == 2'h3 && module_lock |=> module_lock)
      else $error("module lock cleared");
   lock_set_a: assert property (lock_pend && hready && hwdata[10] |=> module_lock)
      else $error("module lock not set by write");
   sec_load_a: assert property (boot_cnt == 2'h1 |-> security_active ==
      (cfg_security_word[15:0] == 16'h4ac8) && backdoor_key_enable == cfg_security_word[31])
      else $error("security state not loaded from config");
   sec_hold_a: assert property (boot_cnt == 2'h3 |->
      $stable(security_active) && $stable(backdoor_key_enable))
      else $error("security state changed after load");

   read_seen_c: cover property (taken && !hwrite);
   refused_seen_c: cover property (program_erase_refused);
   buserr_seen_c: cover property (access_bus_error);
   tick_seen_c: cover property (timing_tick);
endmodule : fts_regs_props

/* File: fts_regs_tb.sv */
// Purpose: self-checking bench for the flash timing, security and protection register bank
// Assumes: ahb-lite master tasks, single whole-word transfers, one slave
// Notes: two reset epochs, since the divider takes only its first write after reset and the security word only changes at reset
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end

module fts_regs_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout, hresp, access_bus_error, program_erase_refused;
   logic timing_tick, backdoor_key_enable, security_active, module_lock;
   logic [31:0] hrdata;
   logic [31:0] cfg_sec = 32'hffff_4ac8;
   logic [31:0] cfg_prot = 32'h0000_0008;
   logic [31:0] cfg_priv = 32'h0000_0020;
   logic av = 1'b0, auser = 1'b0, ape = 1'b0;
   logic [18:0] aaddr = 19'h0;
   int err_count = 0;
   int check_count = 0;
   int per;

   // one slave, so its ready is the bus ready
   assign hready = hreadyout;

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   fts_regs DUT (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .cfg_security_word(cfg_sec),
      .cfg_write_protect(cfg_prot), .cfg_privilege_map(cfg_priv), .access_valid(av),
      .access_addr(aaddr), .access_user(auser), .access_program_erase(ape), .access_bus_error,
      .program_erase_refused, .timing_tick, .backdoor_key_enable, .security_active,
      .module_lock);

   // ***************************************************************
   // bus and access tasks
   // ***************************************************************
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_count++;
         print_verdict();
      end
   endtask : wait_ready

   // one single transfer; read data taken at the data phase's ready edge
   task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(a, 1'b1, d, rd);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(a, 1'b0, 32'h0, rd);
      `CHK("register read", exp, rd)
      `CHK("response", 1'b0, hresp)
   endtask : rd_chk

   // one access request, verdicts looked at in the following cycle
   task automatic acc(input logic [4:0] sec, input logic u, input logic pe,
                      input logic exp_err, input logic exp_ref);
      av <= 1'b1;
      aaddr <= {sec, 14'h0};
      auser <= u;
      ape <= pe;
      @(posedge sys_clk);
      av <= 1'b0;
      @(posedge sys_clk);
      `CHK("bus error", exp_err, access_bus_error)
      `CHK("refused", exp_ref, program_erase_refused)
   endtask : acc

   // cycles between two successive ticks
   task automatic tick_gap(output int p);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (timing_tick !== 1'b1 && n < 200);
      if (n >= 200) begin
         err_count++;
         print_verdict();
      end
      p = 0;
      do begin
         @(posedge sys_clk);
         p++;
      end while (timing_tick !== 1'b1 && p < 200);
   endtask : tick_gap

   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask : do_reset

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      do_reset();
      rd_chk(8'h08, 32'hc000_4ac8);
      `CHK("key enable", 1'b1, backdoor_key_enable)
      `CHK("secured", 1'b1, security_active)
      wr(8'h08, 32'hffff_ffff);
      rd_chk(8'h08, 32'hc000_4ac8);
      rd_chk(8'h10, 32'h0000_0008);
      rd_chk(8'h14, 32'h0000_0020);
      rd_chk(8'h04, 32'h0000_0000);
      rd_chk(8'h0c, 32'h0000_0000);
      acc(5'd3, 1'b0, 1'b1, 1'b0, 1'b1);
      acc(5'd4, 1'b0, 1'b1, 1'b0, 1'b0);
      acc(5'd5, 1'b1, 1'b0, 1'b1, 1'b0);
      acc(5'd5, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(8'h04, 32'h0000_0002);
      rd_chk(8'h04, 32'h0000_0082);
      wr(8'h04, 32'h0000_007f);
      rd_chk(8'h04, 32'h0000_0082);
      tick_gap(per);
      `CHK("tick period", 3, per)
      wr(8'h10, 32'ha5a5_0000);
      rd_chk(8'h10, 32'ha5a5_0000);
      acc(5'd3, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(8'h14, 32'h0000_ffff);
      rd_chk(8'h14, 32'h0000_ffff);
      wr(8'h00, 32'h0000_0400);
      // the lock flop updates on the edge the write returns, so read back first
      rd_chk(8'h00, 32'h0000_0400);
      `CHK("lock", 1'b1, module_lock)
      wr(8'h10, 32'hffff_ffff);
      rd_chk(8'h10, 32'ha5a5_0000);
      wr(8'h14, 32'h0000_0000);
      rd_chk(8'h14, 32'h0000_ffff);
      wr(8'h00, 32'h0000_0000);
      rd_chk(8'h00, 32'h0000_0400);
      `CHK("lock", 1'b1, module_lock)
      // second epoch: unsecured code and the prescaler
      cfg_sec <= 32'h3fff_4ac9;
      do_reset();
      rd_chk(8'h08, 32'h0000_4ac9);
      `CHK("secured", 1'b0, security_active)
      `CHK("key enable", 1'b0, backdoor_key_enable)
      wr(8'h04, 32'h0000_0041);
      rd_chk(8'h04, 32'h0000_00c1);
      tick_gap(per);
      `CHK("tick period", 16, per)
      print_verdict();
   end

   // cuts a hang short
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      print_verdict();
   end
endmodule : fts_regs_tb

bind fts_regs fts_regs_props u_props (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hreadyout, .cfg_security_word, .access_valid, .access_user,
   .access_program_erase, .access_bus_error, .program_erase_refused, .timing_tick,
   .backdoor_key_enable, .security_active, .module_lock);
